// ===== rtl/cpwm_map.vh
// Register indices, field positions, reset values and codes of the complementary PWM timer
`ifndef CPWM_MAP_VH
`define CPWM_MAP_VH

// ==========================================================
// Register indices (byte address = index * 4)
`define CPWM_IDX_PDATA 10'h0E4
`define CPWM_IDX_PDIR 10'h0E6
`define CPWM_IDX_START 10'h137
`define CPWM_IDX_MODE 10'h138
`define CPWM_IDX_FUNC 10'h13A
`define CPWM_IDX_OER1 10'h13B
`define CPWM_IDX_OER2 10'h13C
`define CPWM_IDX_CLKSEL 10'h140
`define CPWM_IDX_PRI 10'h146
`define CPWM_IDX_PERIOD 10'h148
`define CPWM_IDX_DUTY1 10'h14A
`define CPWM_IDX_BUF1 10'h14E
`define CPWM_IDX_SEC 10'h156
`define CPWM_IDX_DUTY2 10'h158
`define CPWM_IDX_DUTY3 10'h15A
`define CPWM_IDX_BUF2 10'h15C
`define CPWM_IDX_BUF3 10'h15E
`define CPWM_IDX_ISTAT 10'h160
`define CPWM_IDX_IMASK 10'h161

// ==========================================================
// Field positions
`define CPWM_ST_S0 0
`define CPWM_ST_S1 1
`define CPWM_ST_CSEL0 2
`define CPWM_ST_CSEL1 3
`define CPWM_ST_MSB 3
`define CPWM_MODE_LSB 5
`define CPWM_MODE_MSB 7
`define CPWM_MODE_PAD 5'h00
`define CPWM_FUNC_MSB 1
`define CPWM_OER1_MSB 5
`define CPWM_OER2_CUT 7
`define CPWM_CLKSEL_MSB 2
`define CPWM_IRQ_PER 0
`define CPWM_IRQ_D1 1
`define CPWM_IRQ_UNF 4
`define CPWM_IRQ_CUT 5
`define CPWM_IRQ_MSB 5

// ==========================================================
// Reset values
`define CPWM_RST_START 4'h0
`define CPWM_RST_MODE 3'h0
`define CPWM_RST_FUNC 2'h3
`define CPWM_RST_OER1 6'h3F
`define CPWM_RST_BYTE 8'h00
`define CPWM_RST_CNT 16'h0000
`define CPWM_RST_PERIOD 16'hFFFF
`define CPWM_RST_IRQ 6'h00
`define CPWM_RST_CLKSEL 3'h0

// ==========================================================
// Count source codes and prescaler taps
`define CPWM_CK_F1 3'h0
`define CPWM_CK_F2 3'h1
`define CPWM_CK_F4 3'h2
`define CPWM_CK_F8 3'h3
`define CPWM_CK_F32 3'h4
`define CPWM_CK_EXT_RISE 3'h5
`define CPWM_CK_EXT_FALL 3'h6
`define CPWM_CK_EXT_BOTH 3'h7
`define CPWM_PRE_F2 0
`define CPWM_PRE_F4 1
`define CPWM_PRE_F8 2
`define CPWM_PRE_F32 4
`define CPWM_CNT_ZERO 16'h0000
`define CPWM_CNT_MAX 16'hFFFF
`define CPWM_CNT_ONE 16'h0001

`endif

// ===== rtl/cpwm_sync3.v
// Three-stage pin synchroniser with agreement filter
module cpwm_sync3
#(
  parameter RST_VAL = 1'b0
)
(
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire din,
  output wire dout
);

  reg meta_ff;
  reg s2_ff;
  reg s3_ff;
  reg stable_ff;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      stable_ff <= RST_VAL;
    end
    else if (clk_en)
    begin
      meta_ff <= din;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
      begin
        stable_ff <= s3_ff;
      end
    end
  end

  assign dout = stable_ff;

endmodule

// ===== rtl/cpwm_timer.v
// Complementary three-phase PWM timer with dead time, pin enables and forced cutoff
//
// Function
// - two 16-bit up/down counters, primary and secondary, form the timebase
// - counters advance on a selected internal divided clock or external count pin
// - primary counter compared with period on each up-count tick; match starts new period
// - period is latched at start and stays fixed while counting
// - counters compared with three duty registers; match sets phase output level
// - six outputs form three complementary normal/counter-phase pairs
// - dead time between pair transitions equals value loaded in primary counter
// - per-pin enable bit: 0 gives PWM to pin, 1 gives port control
// - enabled cutoff with low cutoff input moves all PWM pins to port control
// - during cutoff pin level comes from port data and port direction
// - falling cutoff edge raises an interrupt request, whether or not cutoff is enabled; forced cutoff follows the low level
// - continue bits keep counters running after period match and after secondary/duty 2 match instead of stopping
// - mode bits make buffer registers feed the three duty registers
// - up-count turns down at period match; down turns up at secondary wrap
// - interrupt requests on counter/general register matches and secondary underflow
// - extra output toggles once every PWM period
// - buffered duty values move to duty registers at period match
`include "cpwm_map.vh"

module cpwm_timer
(
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire external_count_input,
  input wire cutoff_n,
  output wire [5:0] pwm_output_pins,
  output wire [5:0] pwm_output_pins_oe,
  output wire period_toggle_output,
  output wire irq
);

  // ==========================================================
  // Functions
  function [15:0] wr16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] sel;
    begin
      wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  function [7:0] wr8;
    input [7:0] old;
    input [31:0] d;
    input [3:0] sel;
    begin
      wr8 = sel[0] ? d[7:0] : old;
    end
  endfunction

  function tick_sel;
    input [2:0] code;
    input [4:0] pre;
    input ext_rise;
    input ext_fall;
    begin
      case (code)
        `CPWM_CK_F1: tick_sel = 1'b1;
        `CPWM_CK_F2: tick_sel = &pre[`CPWM_PRE_F2:0];
        `CPWM_CK_F4: tick_sel = &pre[`CPWM_PRE_F4:0];
        `CPWM_CK_F8: tick_sel = &pre[`CPWM_PRE_F8:0];
        `CPWM_CK_F32: tick_sel = &pre[`CPWM_PRE_F32:0];
        `CPWM_CK_EXT_RISE: tick_sel = ext_rise;
        `CPWM_CK_EXT_FALL: tick_sel = ext_fall;
        default: tick_sel = ext_rise | ext_fall;
      endcase
    end
  endfunction

  // Returns {counter_phase, normal_phase}; both inactive inside the dead band
  function [1:0] phase_lvl;
    input [15:0] pri;
    input [15:0] sec;
    input [15:0] duty;
    input [1:0] act;
    reg n_on;
    reg c_on;
    begin
      n_on = (sec > duty);
      c_on = (pri <= duty);
      phase_lvl = {c_on ~^ act[1], n_on ~^ act[0]};
    end
  endfunction

  // ==========================================================
  // Reset release
  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_n;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  // ==========================================================
  // State
  reg [3:0] start_ff;
  reg [2:0] mode_ff;
  reg [1:0] func_ff;
  reg [5:0] oer1_ff;
  reg oer2_ff;
  reg [7:0] pdata_ff;
  reg [7:0] pdir_ff;
  reg [2:0] clksel_ff;
  reg [15:0] pri_ff;
  reg [15:0] sec_ff;
  reg [15:0] period_ff;
  reg [15:0] per_act_ff;
  reg [15:0] duty_ff [0:2];
  reg [15:0] buf_ff [0:2];
  reg dir_down_ff;
  reg [4:0] pre_ff;
  reg ext_prev_ff;
  reg cut_prev_ff;
  reg [5:0] stat_ff;
  reg [5:0] mask_ff;
  reg irq_ff;
  reg tog_ff;
  reg [5:0] pin_out_ff;
  reg [5:0] pin_oe_ff;
  reg ack_ff;
  reg [31:0] dat_ff;
  reg [31:0] rd_data;
  integer k;
  integer j;

  wire ext_lvl;
  wire cut_lvl;

  // Pins come from outside the clock domain
  cpwm_sync3 #(.RST_VAL(1'b0)) u_sync_ext
  (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din(external_count_input),
    .dout(ext_lvl)
  );

  cpwm_sync3 #(.RST_VAL(1'b1)) u_sync_cut
  (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .din(cutoff_n),
    .dout(cut_lvl)
  );

  // ==========================================================
  // Bus decode
  wire [9:0] idx = wb_adr_i[11:2];
  wire adr_ok = (wb_adr_i[31:12] == 20'h00000) && (wb_adr_i[1:0] == 2'h0);
  wire bus_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  wire wr_now = bus_req & wb_we_i & ack_ff & adr_ok;

  // ==========================================================
  // Timebase control
  wire run = start_ff[`CPWM_ST_S0] & start_ff[`CPWM_ST_S1];
  wire ext_rise = ext_lvl & ~ext_prev_ff;
  wire ext_fall = ~ext_lvl & ext_prev_ff;
  wire tick = run & tick_sel(clksel_ff, pre_ff, ext_rise, ext_fall);
  wire per_match = tick & ~dir_down_ff & (pri_ff == per_act_ff);
  wire unf = tick & dir_down_ff & (sec_ff == `CPWM_CNT_ZERO);
  wire sec_match = tick & (sec_ff == duty_ff[1]);
  wire cut_fall = cut_prev_ff & ~cut_lvl;
  wire forced = oer2_ff & ~cut_lvl;

  wire [15:0] e_pri = dir_down_ff ? pri_ff : pri_ff + `CPWM_CNT_ONE;
  wire [15:0] e_sec = dir_down_ff ? sec_ff : sec_ff + `CPWM_CNT_ONE;
  wire [1:0] lv0 = phase_lvl(e_pri, e_sec, duty_ff[0], func_ff);
  wire [1:0] lv1 = phase_lvl(e_pri, e_sec, duty_ff[1], func_ff);
  wire [1:0] lv2 = phase_lvl(e_pri, e_sec, duty_ff[2], func_ff);
  wire [5:0] pwm_lvl = {lv2, lv1, lv0};

  wire [5:0] pin_port = oer1_ff | {6{forced}};
  wire [5:0] nxt_pin_out = (pin_port & pdata_ff[5:0]) | (~pin_port & pwm_lvl);
  wire [5:0] nxt_pin_oe = (pin_port & pdir_ff[5:0]) | ~pin_port;

  wire [5:0] events;
  assign events[`CPWM_IRQ_PER] = per_match;
  assign events[`CPWM_IRQ_D1 + 0] = tick & ((pri_ff == duty_ff[0]) | (sec_ff == duty_ff[0]));
  assign events[`CPWM_IRQ_D1 + 1] = tick & ((pri_ff == duty_ff[1]) | (sec_ff == duty_ff[1]));
  assign events[`CPWM_IRQ_D1 + 2] = tick & ((pri_ff == duty_ff[2]) | (sec_ff == duty_ff[2]));
  assign events[`CPWM_IRQ_UNF] = unf;
  assign events[`CPWM_IRQ_CUT] = cut_fall;

  // Event set wins over a same-cycle write-one clear
  wire [5:0] stat_clr = (wr_now && idx == `CPWM_IDX_ISTAT && wb_sel_i[0]) ?
    wb_dat_i[`CPWM_IRQ_MSB:0] : `CPWM_RST_IRQ;
  wire [5:0] nxt_stat = (stat_ff & ~stat_clr) | events;

  // ==========================================================
  // Read mux
  always @*
  begin
    rd_data = 32'h00000000;
    case (idx)
      `CPWM_IDX_PDATA: rd_data[7:0] = pdata_ff;
      `CPWM_IDX_PDIR: rd_data[7:0] = pdir_ff;
      `CPWM_IDX_START: rd_data[`CPWM_ST_MSB:0] = start_ff;
      `CPWM_IDX_MODE: rd_data[7:0] = {mode_ff, `CPWM_MODE_PAD};
      `CPWM_IDX_FUNC: rd_data[`CPWM_FUNC_MSB:0] = func_ff;
      `CPWM_IDX_OER1: rd_data[`CPWM_OER1_MSB:0] = oer1_ff;
      `CPWM_IDX_OER2: rd_data[`CPWM_OER2_CUT] = oer2_ff;
      `CPWM_IDX_CLKSEL: rd_data[`CPWM_CLKSEL_MSB:0] = clksel_ff;
      `CPWM_IDX_PRI: rd_data[15:0] = pri_ff;
      `CPWM_IDX_PERIOD: rd_data[15:0] = period_ff;
      `CPWM_IDX_DUTY1: rd_data[15:0] = duty_ff[0];
      `CPWM_IDX_BUF1: rd_data[15:0] = buf_ff[0];
      `CPWM_IDX_SEC: rd_data[15:0] = sec_ff;
      `CPWM_IDX_DUTY2: rd_data[15:0] = duty_ff[1];
      `CPWM_IDX_DUTY3: rd_data[15:0] = duty_ff[2];
      `CPWM_IDX_BUF2: rd_data[15:0] = buf_ff[1];
      `CPWM_IDX_BUF3: rd_data[15:0] = buf_ff[2];
      `CPWM_IDX_ISTAT: rd_data[`CPWM_IRQ_MSB:0] = stat_ff;
      `CPWM_IDX_IMASK: rd_data[`CPWM_IRQ_MSB:0] = mask_ff;
      default: rd_data = 32'h00000000;
    endcase
    if (!adr_ok)
    begin
      rd_data = 32'h00000000;
    end
  end

  // ==========================================================
  // Bus slave and control registers
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
      mode_ff <= `CPWM_RST_MODE;
      func_ff <= `CPWM_RST_FUNC;
      oer1_ff <= `CPWM_RST_OER1;
      oer2_ff <= 1'b0;
      pdata_ff <= `CPWM_RST_BYTE;
      pdir_ff <= `CPWM_RST_BYTE;
      clksel_ff <= `CPWM_RST_CLKSEL;
      period_ff <= `CPWM_RST_PERIOD;
      mask_ff <= `CPWM_RST_IRQ;
      stat_ff <= `CPWM_RST_IRQ;
      irq_ff <= 1'b0;
      for (j = 0; j < 3; j = j + 1)
      begin
        buf_ff[j] <= `CPWM_RST_CNT;
      end
    end
    else if (clk_en)
    begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req & ~ack_ff & ~wb_we_i)
      begin
        dat_ff <= rd_data;
      end
      stat_ff <= nxt_stat;
      irq_ff <= |(nxt_stat & mask_ff);
      if (wr_now)
      begin
        case (idx)
          `CPWM_IDX_PDATA: pdata_ff <= wr8(pdata_ff, wb_dat_i, wb_sel_i);
          `CPWM_IDX_PDIR: pdir_ff <= wr8(pdir_ff, wb_dat_i, wb_sel_i);
          `CPWM_IDX_MODE: if (wb_sel_i[0]) mode_ff <= wb_dat_i[`CPWM_MODE_MSB:`CPWM_MODE_LSB];
          `CPWM_IDX_FUNC: if (wb_sel_i[0]) func_ff <= wb_dat_i[`CPWM_FUNC_MSB:0];
          `CPWM_IDX_OER1: if (wb_sel_i[0]) oer1_ff <= wb_dat_i[`CPWM_OER1_MSB:0];
          `CPWM_IDX_OER2: if (wb_sel_i[0]) oer2_ff <= wb_dat_i[`CPWM_OER2_CUT];
          `CPWM_IDX_CLKSEL: if (wb_sel_i[0]) clksel_ff <= wb_dat_i[`CPWM_CLKSEL_MSB:0];
          `CPWM_IDX_PERIOD: period_ff <= wr16(period_ff, wb_dat_i, wb_sel_i);
          `CPWM_IDX_BUF1: buf_ff[0] <= wr16(buf_ff[0], wb_dat_i, wb_sel_i);
          `CPWM_IDX_BUF2: buf_ff[1] <= wr16(buf_ff[1], wb_dat_i, wb_sel_i);
          `CPWM_IDX_BUF3: buf_ff[2] <= wr16(buf_ff[2], wb_dat_i, wb_sel_i);
          `CPWM_IDX_IMASK: if (wb_sel_i[0]) mask_ff <= wb_dat_i[`CPWM_IRQ_MSB:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Counters, start bits, duty registers
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_ff <= `CPWM_RST_START;
      pri_ff <= `CPWM_RST_CNT;
      sec_ff <= `CPWM_RST_CNT;
      per_act_ff <= `CPWM_RST_PERIOD;
      dir_down_ff <= 1'b0;
      pre_ff <= 5'h00;
      ext_prev_ff <= 1'b0;
      cut_prev_ff <= 1'b1;
      for (k = 0; k < 3; k = k + 1)
      begin
        duty_ff[k] <= `CPWM_RST_CNT;
      end
    end
    else if (clk_en)
    begin
      pre_ff <= pre_ff + 5'h01;
      ext_prev_ff <= ext_lvl;
      cut_prev_ff <= cut_lvl;
      // Live period only reaches the compare while stopped
      if (!run)
      begin
        per_act_ff <= period_ff;
      end
      if (tick)
      begin
        if (!dir_down_ff)
        begin
          if (pri_ff == per_act_ff)
          begin
            dir_down_ff <= 1'b1;
            pri_ff <= pri_ff + `CPWM_CNT_ONE;
            sec_ff <= sec_ff + `CPWM_CNT_ONE;
          end
          else
          begin
            pri_ff <= pri_ff + `CPWM_CNT_ONE;
            sec_ff <= sec_ff + `CPWM_CNT_ONE;
          end
        end
        else if (sec_ff == `CPWM_CNT_ZERO)
        begin
          dir_down_ff <= 1'b0;
          sec_ff <= `CPWM_CNT_MAX;
          pri_ff <= pri_ff - `CPWM_CNT_ONE;
        end
        else
        begin
          pri_ff <= pri_ff - `CPWM_CNT_ONE;
          sec_ff <= sec_ff - `CPWM_CNT_ONE;
        end
      end
      // Software load sets the dead-time offset; it overrides counting
      if (wr_now && idx == `CPWM_IDX_PRI)
      begin
        pri_ff <= wr16(pri_ff, wb_dat_i, wb_sel_i);
      end
      if (wr_now && idx == `CPWM_IDX_SEC)
      begin
        sec_ff <= wr16(sec_ff, wb_dat_i, wb_sel_i);
        dir_down_ff <= 1'b0;
      end
      if (wr_now && idx == `CPWM_IDX_START && wb_sel_i[0])
      begin
        start_ff <= wb_dat_i[`CPWM_ST_MSB:0];
      end
      else
      begin
        if (per_match && !start_ff[`CPWM_ST_CSEL0])
        begin
          start_ff[`CPWM_ST_S0] <= 1'b0;
        end
        if (sec_match && !start_ff[`CPWM_ST_CSEL1])
        begin
          start_ff[`CPWM_ST_S1] <= 1'b0;
        end
      end
      for (k = 0; k < 3; k = k + 1)
      begin
        if (per_match && mode_ff[k])
        begin
          duty_ff[k] <= buf_ff[k];
        end
      end
      if (wr_now && idx == `CPWM_IDX_DUTY1)
      begin
        duty_ff[0] <= wr16(duty_ff[0], wb_dat_i, wb_sel_i);
      end
      if (wr_now && idx == `CPWM_IDX_DUTY2)
      begin
        duty_ff[1] <= wr16(duty_ff[1], wb_dat_i, wb_sel_i);
      end
      if (wr_now && idx == `CPWM_IDX_DUTY3)
      begin
        duty_ff[2] <= wr16(duty_ff[2], wb_dat_i, wb_sel_i);
      end
    end
  end

  // ==========================================================
  // Pin outputs
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out_ff <= 6'h00;
      pin_oe_ff <= 6'h00;
      tog_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      if (per_match)
      begin
        tog_ff <= ~tog_ff;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign pwm_output_pins = pin_out_ff;
  assign pwm_output_pins_oe = pin_oe_ff;
  assign period_toggle_output = tog_ff;
  assign irq = irq_ff;

endmodule

// ===== tb/cpwm_power_stage.sv
// Power stage model: gate inputs, shoot-through watch, overcurrent comparator
module cpwm_power_stage
(
  input wire clk,
  input wire reset_n,
  input wire [5:0] gate,
  input wire [5:0] gate_oe,
  input wire over_current,
  output logic cutoff_n,
  output int shoot_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven gate inputs count as low: each gate is masked with its gate_oe bit
  wire [5:0] lvl = gate & gate_oe;
  wire shoot = (lvl[0] & lvl[1]) | (lvl[2] & lvl[3]) | (lvl[4] & lvl[5]);
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cutoff_n <= 1'b1;
      shoot_cnt <= 0;
    end
    else
    begin
      cutoff_n <= ~over_current;
      shoot_cnt <= shoot_cnt + int'(shoot);
    end
  end
endmodule

// ===== tb/cpwm_timer_checker.sv
// Port-level assertion checker for the complementary PWM timer
`include "cpwm_map.vh"
module cpwm_timer_checker
(
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire external_count_input,
  input wire cutoff_n,
  input wire [5:0] pwm_output_pins,
  input wire [5:0] pwm_output_pins_oe,
  input wire period_toggle_output,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Shadows of the registers that shape the pins, the interrupt and the period toggle
  wire wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & clk_en & wb_sel_i[0];
  wire [9:0] idx = wb_adr_i[11:2];
  logic [5:0] pdata_ff;
  logic [5:0] pdir_ff;
  logic [5:0] oer1_ff;
  logic cut_en_ff;
  logic [5:0] imask_ff;
  logic [1:0] func_ff;
  logic [1:0] run_ff;
  logic [3:0] quiet_ff;
  wire [5:0] sel_pwm = ~oer1_ff;
  wire [5:0] act = pwm_output_pins & sel_pwm;
  wire overlap = (act[0] & act[1]) | (act[2] & act[3]) | (act[4] & act[5]);
  wire [5:0] port_oe = sel_pwm | (oer1_ff & pdir_ff);
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pdata_ff <= 6'h00;
      pdir_ff <= 6'h00;
      oer1_ff <= 6'h3F;
      cut_en_ff <= 1'b0;
      imask_ff <= 6'h00;
      func_ff <= 2'h3;
      run_ff <= 2'h0;
    end
    else if (wr_hit)
    begin
      case (idx)
        `CPWM_IDX_PDATA: pdata_ff <= wb_dat_i[5:0];
        `CPWM_IDX_PDIR: pdir_ff <= wb_dat_i[5:0];
        `CPWM_IDX_OER1: oer1_ff <= wb_dat_i[5:0];
        `CPWM_IDX_OER2: cut_en_ff <= wb_dat_i[`CPWM_OER2_CUT];
        `CPWM_IDX_IMASK: imask_ff <= wb_dat_i[5:0];
        `CPWM_IDX_FUNC: func_ff <= wb_dat_i[1:0];
        `CPWM_IDX_START: run_ff <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end
  // Cycles since the last cause that may still be travelling to the pins
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      quiet_ff <= 4'h0;
    else if (wb_ack_o | ~clk_en | (~cutoff_n & cut_en_ff))
      quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hF)
      quiet_ff <= quiet_ff + 4'h1;
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_cut_held;
    (!cutoff_n && cut_en_ff && clk_en && !wb_ack_o) [*7];
  endsequence
  sequence s_mask_off;
    (imask_ff == 6'h00 && clk_en) [*2];
  endsequence
  a_ack_after_req:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_pulse:
    assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rdata_holds:
    assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i && clk_en))
    else $error("read data changed without a read");
  a_pin_routing:
    assert property (quiet_ff >= 4'h8 |-> pwm_output_pins_oe == port_oe
      && ((pwm_output_pins ^ pdata_ff) & oer1_ff & pdir_ff) == 6'h00)
    else $error("pin routing differs from enable bits");
  a_cutoff_port:
    assert property (s_cut_held |-> pwm_output_pins_oe == pdir_ff
      && ((pwm_output_pins ^ pdata_ff) & pdir_ff) == 6'h00)
    else $error("pins not under port control in cutoff");
  a_cutoff_irq:
    assert property ($fell(cutoff_n) && imask_ff[`CPWM_IRQ_CUT] && clk_en |-> ##[1:8] irq)
    else $error("no interrupt after cutoff edge");
  a_irq_masked:
    assert property (s_mask_off |-> !irq)
    else $error("interrupt while all sources masked");
  a_pair_exclusive:
    assert property (quiet_ff >= 4'h8 && func_ff == 2'h3 |-> !overlap)
    else $error("both outputs of a pair active");
  a_toggle_running:
    assert property ($changed(period_toggle_output) |-> $past(run_ff) == 2'h3)
    else $error("period toggle moved while stopped");
endmodule
bind cpwm_timer cpwm_timer_checker i_cpwm_timer_checker (.clk, .reset_n, .clk_en, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .external_count_input, .cutoff_n, .pwm_output_pins, .pwm_output_pins_oe,
  .period_toggle_output, .irq);

// ===== tb/cpwm_timer_tb_top.sv
// Self-checking bench of the complementary PWM timer
`include "cpwm_map.vh"
module cpwm_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic ext_cnt = 1'b0;
  logic ext_on = 1'b0;
  logic trip = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire cutoff_n;
  wire [5:0] pins;
  wire [5:0] oe;
  wire tog;
  wire irq;
  int shoot;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] rq;
  localparam int M = 32;
  localparam int P = 4;
  localparam int PER = 2 * (M + 2 - P);
  int duty [3] = '{12, 16, 20};
  int mult [8] = '{1, 2, 4, 8, 32, 8, 8, 4};
  always #50 clk = ~clk;
  // External source: four clocks high, four low, slow enough for the pin filter
  always
  begin
    repeat (4) @(posedge clk);
    if (ext_on)
      ext_cnt <= ~ext_cnt;
  end
  cpwm_timer i_cpwm_timer (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .external_count_input(ext_cnt), .cutoff_n(cutoff_n), .pwm_output_pins(pins),
    .pwm_output_pins_oe(oe), .period_toggle_output(tog), .irq(irq));
  cpwm_power_stage i_cpwm_power_stage (.clk(clk), .reset_n(reset_n), .gate(pins),
    .gate_oe(oe), .over_current(trip), .cutoff_n(cutoff_n), .shoot_cnt(shoot));
  // ==========================================
  // Shared tasks
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {20'h00000, idx, 2'h0};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic chk(input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 16'h0000);
    cmp_reg(rq, exp);
  endtask
  task automatic tog_len(output int n);
    logic t;
    n = 0;
    t = tog;
    while (tog === t && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    chk(`CPWM_IDX_START, 32'h00000000);
    chk(`CPWM_IDX_FUNC, 32'h00000003);
    chk(`CPWM_IDX_OER1, 32'h0000003F);
    chk(`CPWM_IDX_PERIOD, 32'h0000FFFF);
    chk(10'h100, 32'h00000000);
    wr(`CPWM_IDX_PDIR, 16'h003F);
    wr(`CPWM_IDX_PDATA, 16'h002A);
    repeat (3) @(posedge clk);
    cmp_reg({26'h0, oe}, 32'h0000003F);
    cmp_reg({26'h0, pins}, 32'h0000002A);
    $display("test regs done");
  endtask
  task automatic t_pwm;
    int n;
    int h[6] = '{default: 0};
    wr(`CPWM_IDX_OER1, 16'h0000);
    wr(`CPWM_IDX_PERIOD, 16'h0020);
    wr(`CPWM_IDX_PRI, 16'h0004);
    wr(`CPWM_IDX_SEC, 16'h0000);
    wr(`CPWM_IDX_DUTY1, 16'h000C);
    wr(`CPWM_IDX_DUTY2, 16'h0010);
    wr(`CPWM_IDX_DUTY3, 16'h0014);
    wr(`CPWM_IDX_START, 16'h000F);
    tog_len(n);
    tog_len(n);
    cmp_cnt(n, PER);
    for (int i = 0; i < PER; i++)
    begin
      @(posedge clk);
      for (int b = 0; b < 6; b++)
        h[b] += int'(pins[b] === 1'b1);
    end
    for (int k = 0; k < 3; k++)
    begin
      cmp_cnt(h[2 * k], 2 * (M - duty[k] - P + 1));
      cmp_cnt(h[2 * k + 1], 2 * (duty[k] + 1 - P));
    end
    wr(`CPWM_IDX_PERIOD, 16'h0040);
    tog_len(n);
    tog_len(n);
    cmp_cnt(n, PER);
    $display("test pwm done");
  endtask
  task automatic t_buf;
    int n;
    tog_len(n);
    wr(`CPWM_IDX_BUF1, 16'h0018);
    wr(`CPWM_IDX_MODE, 16'h00E0);
    chk(`CPWM_IDX_MODE, 32'h000000E0);
    chk(`CPWM_IDX_DUTY1, 32'h0000000C);
    tog_len(n);
    chk(`CPWM_IDX_DUTY1, 32'h00000018);
    $display("test buffer done");
  endtask
  task automatic t_clk;
    int n;
    for (int c = 0; c < 8; c++)
    begin
      ext_on <= (c >= 5);
      wr(`CPWM_IDX_CLKSEL, 16'(c));
      tog_len(n);
      tog_len(n);
      tog_len(n);
      cmp_cnt(n, PER * mult[c]);
    end
    wr(`CPWM_IDX_CLKSEL, 16'h0000);
    $display("test clock sources done");
  endtask
  task automatic t_cut(input logic en);
    wr(`CPWM_IDX_PDIR, 16'h003C);
    wr(`CPWM_IDX_PDATA, 16'h0015);
    wr(`CPWM_IDX_OER2, en ? 16'h0080 : 16'h0000);
    wr(`CPWM_IDX_IMASK, 16'h0020);
    wr(`CPWM_IDX_ISTAT, 16'h003F);
    trip <= 1'b1;
    repeat (8) @(posedge clk);
    cmp_reg({26'h0, oe}, en ? 32'h0000003C : 32'h0000003F);
    if (en)
      cmp_reg({26'h0, pins & oe}, 32'h00000014);
    cmp_reg({31'h0, irq}, 32'h00000001);
    trip <= 1'b0;
    repeat (8) @(posedge clk);
    wr(`CPWM_IDX_ISTAT, 16'h0020);
    repeat (3) @(posedge clk);
    cmp_reg({31'h0, irq}, 32'h00000000);
    $display("test cutoff done");
  endtask
  task automatic t_irq;
    int n;
    logic t;
    wr(`CPWM_IDX_IMASK, 16'h0011);
    wr(`CPWM_IDX_ISTAT, 16'h003F);
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    cmp_reg({31'h0, irq}, 32'h00000001);
    clk_en <= 1'b0;
    @(posedge clk);
    t = tog;
    repeat (70) @(posedge clk);
    cmp_reg({31'h0, tog}, {31'h0, t});
    clk_en <= 1'b1;
    wr(`CPWM_IDX_START, 16'h000B);
    tog_len(n);
    chk(`CPWM_IDX_START, 32'h0000000A);
    bus(1'b0, `CPWM_IDX_ISTAT, 16'h0000);
    cmp_reg(rq & 32'h00000011, 32'h00000011);
    wr(`CPWM_IDX_IMASK, 16'h0000);
    repeat (3) @(posedge clk);
    cmp_reg({31'h0, irq}, 32'h00000000);
    wr(`CPWM_IDX_ISTAT, 16'h0011);
    wr(`CPWM_IDX_IMASK, 16'h0011);
    bus(1'b0, `CPWM_IDX_ISTAT, 16'h0000);
    cmp_reg(rq & 32'h00000011, 32'h00000000);
    cmp_reg({31'h0, irq}, 32'h00000000);
    cmp_cnt(shoot, 0);
    $display("test interrupt done");
  endtask
  // ==========================================
  // Sequence and verdict
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_pwm;
    t_buf;
    t_clk;
    t_cut(1'b1);
    t_cut(1'b0);
    t_irq;
    tally_and_finish;
  end
  // Whole run is about 13000 cycles; the guard allows well over twice that
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
